// File: rtl/scl_pkg.sv
// Shared constants and carriers for the switch card serial link.
// Assumes one 20 MHz core clock and a synchronous active-low reset.
package scl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Core clock period in picoseconds
  localparam int unsigned CORE_PERIOD_PS = 50000;
  // Bus E clock period in picoseconds (1.78977 MHz)
  localparam int unsigned ECLK_PERIOD_PS = 558731;
  // Core cycles per E clock half period, rounded down, at least one
  localparam int unsigned ECLK_HALF_RAW = ECLK_PERIOD_PS / (2 * CORE_PERIOD_PS);
  localparam int unsigned ECLK_HALF_CYC = (ECLK_HALF_RAW < 1) ? 1 : ECLK_HALF_RAW;
  // Width of the half-period divider counter
  localparam int unsigned ECLK_DIV_W = 4;

  // Bits in one serial byte
  localparam int unsigned BYTE_BITS = 8;
  // Reset value of the output shifter
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  // All ones loaded into the cycle-count shifter
  localparam logic [7:0] COUNT_LOAD = 8'hFF;

  // Address-step countdown; the line is held low for one core cycle more than this
  localparam logic [7:0] STEP_HOLD_CYC = 8'h10;
  // Address-clear countdown; the line is held high for one core cycle more than this
  localparam logic [7:0] CLEAR_HOLD_CYC = 8'h04;
  // Latch strobe countdown; the strobe is held high for one core cycle more than this
  localparam logic [7:0] STROBE_HOLD_CYC = 8'h04;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Card-side pins driven by the main board
  typedef struct packed {
    logic serial_clk;
    logic relay_serial_data;
    logic slot_enable_n;
    logic ident_addr_clear;
    logic ident_addr_step_n;
    logic latch_strobe;
  } scl_card_out_s;

  // Processor-side command strobes
  typedef struct packed {
    logic relay_write;
    logic [7:0] relay_byte;
    logic ident_begin;
    logic ident_step;
    logic ident_end;
    logic strobe;
  } scl_cmd_s;

endpackage

// File: rtl/scl_eclk_div.sv
// E clock divider: a one-cycle enable at each rising and falling edge
// of the modelled bus E clock.
// Assumes the core clock rate named in scl_pkg.
`timescale 1ns/1ps
module scl_eclk_div (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Enables
  output logic rise_en,
  output logic fall_en,
  output logic eclk_level
);

  // ---------------------------------------------------------------
  // Divider state
  // ---------------------------------------------------------------
  logic [scl_pkg::ECLK_DIV_W-1:0] cnt; // Half-period counter
  logic [scl_pkg::ECLK_DIV_W-1:0] next_cnt;
  logic next_eclk_level;
  logic next_rise_en;
  logic next_fall_en;

  // Next values: toggle the E level at each half period end
  always_comb begin
    next_cnt = cnt + 1'b1;
    next_eclk_level = eclk_level;
    next_rise_en = 1'b0;
    next_fall_en = 1'b0;
    if (cnt == scl_pkg::ECLK_DIV_W'(scl_pkg::ECLK_HALF_CYC - 1)) begin
      next_cnt = '0;
      next_eclk_level = ~eclk_level;
      next_rise_en = ~eclk_level;
      next_fall_en = eclk_level;
    end
  end

  // Register stage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt <= '0;
      eclk_level <= 1'b0;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      eclk_level <= next_eclk_level;
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
    end
  end

endmodule

// File: rtl/scl_main_link.sv
// Main-board end of the relay card serial link: relay byte shifter,
// gated serial clock, identification readout and latch strobe.
// Assumes processor strobes are synchronous to core_clk and card
// inputs arrive asynchronously.
//
// How it works
// - Eight-bit parallel shifter sends one bit per clock
// - Write loads byte, count all ones, flag high
// - After write, gated E clock drives serial clock
// - Eight pulses counted, then flag low, clock stops
// - Delayed inverted clock shifts relay data out
// - Reads identification and sends relay data serially
// - Select held low for whole identification readout
// - Address clear pulsed high once per readout
// - Address step held low until memory settles
// - Each relay byte returns one identification byte
// - Repeat step and eight-clock shift per location
// - Returned bits made parallel for processor read
// - E clock is oscillator over four, 1.78977MHz; the divider here gives core clock over ten, 2 MHz
// - Latch strobe high after all bytes shifted
`timescale 1ns/1ps
module scl_main_link (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Processor commands
  input wire scl_pkg::scl_cmd_s cmd,
  // Card pins driven by the board
  output scl_pkg::scl_card_out_s card_out,
  // Returned identification line from the card
  input wire logic card_ident_serial_data,
  // Processor-visible status
  output logic count_flag,
  output logic ident_busy,
  output logic [7:0] ident_byte,
  output logic ident_valid,
  output logic write_refused
);

  // ---------------------------------------------------------------
  // E clock enables
  // ---------------------------------------------------------------
  logic e_rise; // One-cycle pulse at E rising edge
  logic e_fall; // One-cycle pulse at E falling edge

  // Oscillator over four, modelled by the divider
  scl_eclk_div u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .rise_en(e_rise),
    .fall_en(e_fall),
    .eclk_level()
  );

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  logic ident_meta; // First stage, read only by the second
  logic ident_sync; // Safe copy of the returned bit

  // Two flops on the card line
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ident_meta <= 1'b0;
      ident_sync <= 1'b0;
    end else begin
      ident_meta <= card_ident_serial_data;
      ident_sync <= ident_meta;
    end
  end

  // ---------------------------------------------------------------
  // Serial shift engine
  // ---------------------------------------------------------------
  logic [7:0] tx_shift; // Relay byte shifter
  logic [7:0] next_tx_shift;
  logic [7:0] cnt_shift; // Cycle-count shifter
  logic [7:0] next_cnt_shift;
  logic [7:0] rx_shift; // Serial-in identification shifter
  logic [7:0] next_rx_shift;
  logic active; // Shift window open
  logic next_active;
  logic armed; // Write seen, waiting for window
  logic next_armed;
  logic sclk; // Serial clock driven to cards
  logic next_sclk;
  logic started; // Set at the first pulse end; the shift does not wait on it
  logic next_started;
  logic data_bit; // Relay data line
  logic next_data_bit;
  logic next_count_flag;
  logic next_write_refused;
  logic [7:0] next_ident_byte;
  logic next_ident_valid;

  // Next values of the shift engine
  always_comb begin
    next_tx_shift = tx_shift;
    next_cnt_shift = cnt_shift;
    next_rx_shift = rx_shift;
    next_active = active;
    next_armed = armed;
    next_sclk = sclk;
    next_started = started;
    next_data_bit = data_bit;
    next_count_flag = count_flag;
    next_write_refused = 1'b0;
    next_ident_byte = ident_byte;
    next_ident_valid = 1'b0;
    // Refusal is flagged apart, so a refused write never swallows an E edge
    if (cmd.relay_write && (count_flag || armed)) begin
      // Overlapping write would corrupt the byte in flight
      next_write_refused = 1'b1;
    end
    if (cmd.relay_write && !count_flag && !armed) begin
      next_tx_shift = cmd.relay_byte;
      next_cnt_shift = scl_pkg::COUNT_LOAD;
      next_count_flag = 1'b1;
      next_armed = 1'b1;
      next_started = 1'b0;
      next_data_bit = cmd.relay_byte[7];
    end else if (armed && e_fall) begin
      // Write cycle over: open the window at an E low phase
      next_armed = 1'b0;
      next_active = 1'b1;
    end else if (active && e_rise && count_flag) begin
      // Gated E high drives the serial clock
      next_sclk = 1'b1;
      // Card samples relay data; board samples returned bit
      next_rx_shift = {rx_shift[6:0], ident_sync};
      // Count a pulse by shifting a zero
      next_cnt_shift = {cnt_shift[6:0], 1'b0};
    end else if (active && e_fall && sclk) begin
      next_sclk = 1'b0;
      if (cnt_shift == 8'h00) begin
        // Eight pulses done: flag low, no more clocks
        next_count_flag = 1'b0;
        next_active = 1'b0;
        next_ident_byte = rx_shift;
        next_ident_valid = 1'b1;
      end
      // Inverted clock shifts at every pulse end, the first one included
      if (started) begin
        next_tx_shift = {tx_shift[6:0], 1'b0};
        next_data_bit = tx_shift[6];
      end else begin
        next_started = 1'b1;
        next_tx_shift = {tx_shift[6:0], 1'b0};
        next_data_bit = tx_shift[6];
      end
    end
  end

  // Register stage of the shift engine
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_shift <= scl_pkg::SHIFT_RESET;
      cnt_shift <= scl_pkg::SHIFT_RESET;
      rx_shift <= scl_pkg::SHIFT_RESET;
      active <= 1'b0;
      armed <= 1'b0;
      sclk <= 1'b0;
      started <= 1'b0;
      data_bit <= 1'b0;
      count_flag <= 1'b0;
      write_refused <= 1'b0;
      ident_byte <= scl_pkg::SHIFT_RESET;
      ident_valid <= 1'b0;
    end else begin
      tx_shift <= next_tx_shift;
      cnt_shift <= next_cnt_shift;
      rx_shift <= next_rx_shift;
      active <= next_active;
      armed <= next_armed;
      sclk <= next_sclk;
      started <= next_started;
      data_bit <= next_data_bit;
      count_flag <= next_count_flag;
      write_refused <= next_write_refused;
      ident_byte <= next_ident_byte;
      ident_valid <= next_ident_valid;
    end
  end

  // ---------------------------------------------------------------
  // Identification control lines
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCL_ID_IDLE,
    SCL_ID_CLEAR,
    SCL_ID_READY,
    SCL_ID_STEP
  } scl_id_state_e;

  scl_id_state_e id_state; // Readout sequencer
  scl_id_state_e next_id_state;
  logic [7:0] hold_cnt; // Pulse width timer
  logic [7:0] next_hold_cnt;
  logic sel_n; // Card select, active low
  logic next_sel_n;
  logic addr_clear;
  logic next_addr_clear;
  logic step_n;
  logic next_step_n;
  logic next_ident_busy;

  // Next values of the readout sequencer
  always_comb begin
    next_id_state = id_state;
    next_hold_cnt = hold_cnt;
    next_sel_n = sel_n;
    next_addr_clear = addr_clear;
    next_step_n = step_n;
    next_ident_busy = ident_busy;
    unique case (id_state)
      SCL_ID_IDLE: begin
        if (cmd.ident_begin) begin
          next_sel_n = 1'b0;
          next_addr_clear = 1'b1; // Single clear per readout
          next_hold_cnt = scl_pkg::CLEAR_HOLD_CYC;
          next_ident_busy = 1'b1;
          next_id_state = SCL_ID_CLEAR;
        end
      end
      SCL_ID_CLEAR: begin
        if (hold_cnt == 8'h00) begin
          next_addr_clear = 1'b0;
          next_id_state = SCL_ID_READY;
        end else begin
          next_hold_cnt = hold_cnt - 8'h01;
        end
      end
      SCL_ID_READY: begin
        if (cmd.ident_end) begin
          next_sel_n = 1'b1; // Select released only at the end
          next_ident_busy = 1'b0;
          next_id_state = SCL_ID_IDLE;
        end else if (cmd.ident_step && !count_flag) begin
          // Step moves counter off zero, so location one first
          next_step_n = 1'b0;
          next_hold_cnt = scl_pkg::STEP_HOLD_CYC;
          next_id_state = SCL_ID_STEP;
        end
      end
      SCL_ID_STEP: begin
        // Held low until the memory outputs settle
        if (hold_cnt == 8'h00) begin
          next_step_n = 1'b1;
          next_id_state = SCL_ID_READY;
        end else begin
          next_hold_cnt = hold_cnt - 8'h01;
        end
      end
    endcase
  end

  // Register stage of the readout sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      id_state <= SCL_ID_IDLE;
      hold_cnt <= 8'h00;
      sel_n <= 1'b1;
      addr_clear <= 1'b0;
      step_n <= 1'b1;
      ident_busy <= 1'b0;
    end else begin
      id_state <= next_id_state;
      hold_cnt <= next_hold_cnt;
      sel_n <= next_sel_n;
      addr_clear <= next_addr_clear;
      step_n <= next_step_n;
      ident_busy <= next_ident_busy;
    end
  end

  // ---------------------------------------------------------------
  // Latch strobe
  // ---------------------------------------------------------------
  logic strobe; // Latch strobe to all cards
  logic next_strobe;
  logic [7:0] strobe_cnt;
  logic [7:0] next_strobe_cnt;

  // Strobe only when no byte is in flight, so all bits are in place
  always_comb begin
    next_strobe = strobe;
    next_strobe_cnt = strobe_cnt;
    if (strobe) begin
      if (strobe_cnt == 8'h00) begin
        next_strobe = 1'b0; // Falling edge enables card outputs
      end else begin
        next_strobe_cnt = strobe_cnt - 8'h01;
      end
    end else if (cmd.strobe && !count_flag && !armed) begin
      next_strobe = 1'b1;
      next_strobe_cnt = scl_pkg::STROBE_HOLD_CYC;
    end
  end

  // Register stage; reset drives strobe low before any pulse
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      strobe <= 1'b0;
      strobe_cnt <= 8'h00;
    end else begin
      strobe <= next_strobe;
      strobe_cnt <= next_strobe_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Card pin bundle, all from flops
  // ---------------------------------------------------------------
  assign card_out.serial_clk = sclk;
  assign card_out.relay_serial_data = data_bit;
  assign card_out.slot_enable_n = sel_n;
  assign card_out.ident_addr_clear = addr_clear;
  assign card_out.ident_addr_step_n = step_n;
  assign card_out.latch_strobe = strobe;

endmodule

// File: sim/scl_main_link_assertions.sv
// Checker for the main-board serial link, watching only its ports.
// Assumes one core clock domain and the bind at the foot of the file.
`timescale 1ns/1ps
module scl_main_link_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Watched ports
  input wire scl_pkg::scl_cmd_s cmd,
  input wire scl_pkg::scl_card_out_s card_out,
  input wire logic card_ident_serial_data,
  input wire logic count_flag,
  input wire logic ident_busy,
  input wire logic [7:0] ident_byte,
  input wire logic ident_valid,
  input wire logic write_refused
);
  // ---------------------------------------------------------------
  // Pulse counter
  // ---------------------------------------------------------------
  logic [3:0] pulses; // Serial clock rises since the last taken write
  logic [3:0] next_pulses;
  logic sclk_q; // Serial clock one cycle back
  // Cleared by a taken write, so each byte is judged on its own
  always_comb begin
    next_pulses = pulses + 4'(card_out.serial_clk & ~sclk_q);
    if (cmd.relay_write && !count_flag) begin
      next_pulses = 4'h0;
    end
  end
  // Registers only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulses <= 4'h0;
      sclk_q <= 1'b0;
    end else begin
      pulses <= next_pulses;
      sclk_q <= card_out.serial_clk;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  write_sets_flag_a: assert property (cmd.relay_write && !count_flag |=> count_flag)
    else $error("count flag did not rise after a write");
  window_opens_a: assert property ($rose(count_flag) |-> ##[1:40] card_out.serial_clk)
    else $error("serial clock did not start");
  clock_gated_a: assert property (card_out.serial_clk |-> count_flag)
    else $error("serial clock outside the shift window");
  eight_pulses_a: assert property ($fell(count_flag) |-> pulses == 4'h8)
    else $error("shift window did not hold eight pulses");
  data_steady_a: assert property (card_out.serial_clk |-> $stable(card_out.relay_serial_data))
    else $error("relay data moved while serial clock high");
  valid_pairs_a: assert property (ident_valid == $fell(count_flag))
    else $error("returned byte not paired with end of shift");
  refuse_busy_a: assert property (cmd.relay_write && count_flag |=> write_refused)
    else $error("write during shift not refused");
  clear_width_a: assert property ($rose(card_out.ident_addr_clear) |->
    card_out.ident_addr_clear [*5] ##1 !card_out.ident_addr_clear)
    else $error("address clear pulse width wrong");
  step_hold_a: assert property ($fell(card_out.ident_addr_step_n) |->
    !card_out.ident_addr_step_n [*8] ##9 !card_out.ident_addr_step_n
    ##1 card_out.ident_addr_step_n)
    else $error("address step hold wrong");
  step_selected_a: assert property (!card_out.ident_addr_step_n |->
    !card_out.slot_enable_n && ident_busy)
    else $error("address step outside a readout");
  strobe_width_a: assert property ($rose(card_out.latch_strobe) |->
    card_out.latch_strobe [*5] ##1 !card_out.latch_strobe)
    else $error("latch strobe width wrong");
  strobe_idle_a: assert property (card_out.latch_strobe |-> !count_flag)
    else $error("latch strobe during a shift");
  // Main scenarios
  write_c: cover property (cmd.relay_write && !count_flag);
  refuse_c: cover property (write_refused);
  ident_c: cover property (ident_valid && ident_busy);
  strobe_c: cover property ($fell(card_out.latch_strobe));
endmodule
bind scl_main_link scl_main_link_assertions i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .cmd(cmd), .card_out(card_out), .card_ident_serial_data(card_ident_serial_data),
  .count_flag(count_flag), .ident_busy(ident_busy), .ident_byte(ident_byte),
  .ident_valid(ident_valid), .write_refused(write_refused));

// File: sim/scl_card_model.sv
// Behavioural plug-in relay card: address counter, ID memory, driver chain.
// Assumes the card pins come straight from scl_main_link.
`timescale 1ns/1ps
module scl_card_model (
  // Card pins from the main board
  input wire scl_pkg::scl_card_out_s pins,
  // Returned identification line
  output logic card_ident_serial_data,
  // Relay view for the bench
  output logic [15:0] relay_on,
  output logic driver_out_enable_n
);
  logic [11:0] addr; // Card address counter
  logic [7:0] id_sh; // Identification output shifter
  logic [15:0] chain; // Two drivers joined in one chain
  logic [15:0] drv_q; // Latched driver outputs
  logic last; // Last bit driven while selected
  logic armed; // A strobe has been high since power-up
  // Content follows the address so the bench can predict it
  function automatic logic [7:0] id_mem(input logic [11:0] a);
    return a[7:0] ^ 8'h5A ^ {a[11:8], 4'h0};
  endfunction
  initial begin
    addr = 12'h000;
    id_sh = 8'h00;
    chain = 16'h0000;
    drv_q = 16'hFFFF;
    last = 1'b0;
    armed = 1'b0;
    driver_out_enable_n = 1'b1;
  end
  // Clear resets the counter to zero
  always @(posedge pins.ident_addr_clear) begin
    addr = 12'h000;
  end
  // Step low increments, so location one is read first
  always @(negedge pins.ident_addr_step_n) begin
    addr = addr + 12'h001;
    id_sh = id_mem(addr);
  end
  // Bits leave MSB first on each falling clock; filler is junk
  always @(negedge pins.serial_clk) begin
    id_sh = {id_sh[6:0], ~id_sh[7]};
  end
  // Shared clock, first driver feeds the second
  always @(posedge pins.serial_clk) begin
    if (!pins.slot_enable_n) begin
      chain = {chain[14:0], pins.relay_serial_data};
    end
  end
  // Every card latches, selected or not
  always @(posedge pins.latch_strobe) begin
    drv_q = chain;
    armed = 1'b1;
  end
  // Outputs enabled from the first strobe fall; a power-up glitch is ignored
  always @(negedge pins.latch_strobe) begin
    if (armed) begin
      driver_out_enable_n = 1'b0;
    end
  end
  // Low output energises a relay
  assign relay_on = driver_out_enable_n ? 16'h0000 : ~drv_q;
  // Deselected memory no longer drives: inverse of the last bit
  always @* begin
    if (!pins.slot_enable_n) begin
      last = id_sh[7];
    end
  end
  assign card_ident_serial_data = pins.slot_enable_n ? ~last : id_sh[7];
endmodule

// File: sim/switch_card_serial_link_bench.sv
// Self-checking bench for scl_main_link with one behavioural card.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module switch_card_serial_link_bench;
  logic core_clk, rst_b;
  scl_pkg::scl_cmd_s cmd;
  scl_pkg::scl_card_out_s card_out;
  logic card_ident_serial_data, count_flag, ident_busy, ident_valid, write_refused;
  logic [7:0] ident_byte, rx, got_id, b, prev_b;
  logic [15:0] relay_on;
  logic drv_oe_n, sclk_q;
  int failures, n_compared, cyc, npulse;
  scl_main_link i_dut (.core_clk(core_clk), .rst_b(rst_b), .cmd(cmd), .card_out(card_out),
    .card_ident_serial_data(card_ident_serial_data), .count_flag(count_flag),
    .ident_busy(ident_busy), .ident_byte(ident_byte), .ident_valid(ident_valid),
    .write_refused(write_refused));
  scl_card_model i_card (.pins(card_out), .card_ident_serial_data(card_ident_serial_data),
    .relay_on(relay_on), .driver_out_enable_n(drv_oe_n));
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  // Collects the stream at serial clock rises and each returned byte
  always @(negedge core_clk) begin
    if (card_out.serial_clk === 1'b1 && sclk_q === 1'b0) begin
      rx = {rx[6:0], card_out.relay_serial_data};
      npulse++;
    end
    sclk_q = card_out.serial_clk;
    if (ident_valid === 1'b1) begin
      got_id = ident_byte;
    end
  end
  // Whole run needs about 1100 cycles; the 20000 limit, some eighteen times that, means a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic [7:0] exp_id(input int k);
    return 8'(k) ^ 8'h5A;
  endfunction
  function automatic logic sel(input int k);
    case (k)
      0: return count_flag;
      1: return card_out.ident_addr_step_n;
      2: return card_out.ident_addr_clear;
      default: return card_out.latch_strobe;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait for a level; running out counts as a mismatch
  task automatic wait_lvl(input int k, input logic lvl);
    for (int i = 0; i < 400 && sel(k) !== lvl; i++) begin
      @(negedge core_clk);
    end
    if (sel(k) !== lvl) begin
      failures++;
      $display("wait ran out at %0t", $time);
    end
  endtask
  // Sends one byte, then checks pulse count and bit order on the pins
  task automatic send(input logic [7:0] v);
    cmd.relay_byte = v;
    cmd.relay_write = 1'b1;
    npulse = 0;
    @(negedge core_clk);
    cmd.relay_write = 1'b0;
    wait_lvl(0, 1'b0);
    @(negedge core_clk);
    check(16'(npulse), 16'h0008);
    check({8'h00, rx}, {8'h00, v});
  endtask
  initial begin
    cmd = '0;
    rst_b = 1'b0;
    {rx, got_id, b, prev_b, sclk_q} = '0;
    void'($urandom(32'h427B));
    repeat (3) @(negedge core_clk);
    check({10'h000, card_out}, 16'h000A);
    rst_b = 1'b1;
    @(negedge core_clk);
    // Corner bytes, then random ones
    send(8'h00);
    send(8'hFF);
    send(8'h81);
    repeat (5) send(8'($urandom));
    $display("relay byte test done");
    // Second write held up during a shift is refused
    cmd.relay_byte = 8'hC3;
    cmd.relay_write = 1'b1;
    npulse = 0;
    @(negedge core_clk);
    cmd.relay_byte = 8'h3C;
    @(negedge core_clk);
    cmd.relay_write = 1'b0;
    check({15'h0000, write_refused}, 16'h0001);
    wait_lvl(0, 1'b0);
    @(negedge core_clk);
    check({8'h00, rx}, 16'h00C3);
    $display("refusal test done");
    // Readout of three locations, each paid for with one relay byte
    cmd.ident_begin = 1'b1;
    @(negedge core_clk);
    cmd.ident_begin = 1'b0;
    @(negedge core_clk);
    check({14'h0000, card_out.slot_enable_n, ident_busy}, 16'h0001);
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
    for (int k = 1; k <= 3; k++) begin
      cmd.ident_step = 1'b1;
      @(negedge core_clk);
      cmd.ident_step = 1'b0;
      wait_lvl(1, 1'b0);
      wait_lvl(1, 1'b1);
      prev_b = b;
      b = 8'($urandom);
      send(b);
      check({8'h00, got_id}, {8'h00, exp_id(k)});
    end
    cmd.ident_end = 1'b1;
    @(negedge core_clk);
    cmd.ident_end = 1'b0;
    repeat (2) @(negedge core_clk);
    check({14'h0000, card_out.slot_enable_n, ident_busy}, 16'h0002);
    $display("readout test done");
    // Strobe latches the chain and enables the drivers
    check({15'h0000, drv_oe_n}, 16'h0001);
    cmd.strobe = 1'b1;
    @(negedge core_clk);
    cmd.strobe = 1'b0;
    wait_lvl(3, 1'b1);
    wait_lvl(3, 1'b0);
    @(negedge core_clk);
    check({15'h0000, drv_oe_n}, 16'h0000);
    check(relay_on, ~{prev_b, b});
    $display("strobe test done");
    end_of_test();
  end
endmodule
